// file: design/olsc_pkg.sv
// Package: constants and types for on-state open-load and sense-mode control
// Operation
// RULE1: High ratio: check open load continuously while channel conducts.
// RULE2: Open load found: fault pin low, flag set, channel stays on.
// RULE3: Fault pin releases when cause goes; latched flag stays set.
// RULE4: High ratio: fault read while channel off clears the flag.
// RULE5: High ratio: read while on clears flag only if cause gone.
// RULE6: Low ratio: discrete checks only, and only with fast slew.
// RULE7: Internal PWM low ratio: check at first turn-off 150 ms after last.
// RULE8: Direct input low ratio: check at each input turn-off; none at 100%.
// RULE9: Direct-input disable bit D5 makes device ignore that input.
// RULE10: Low ratio: flag clears on read after a clean completed check.
// RULE11: Sense output carries channel 0, channel 1 or temperature.
// RULE12: Bit a only: ch0; bit b only: ch1; both: temperature.
// RULE13: Overcurrent windows active: sensing off, sync pin held high.
// RULE14: Track-and-hold bit: 0 instantaneous, 1 track-and-hold.
// RULE15: Instantaneous: no channel current shown after turn-off.
// RULE16: Track-and-hold: keep pre-turn-off current after turn-off.
// RULE17: Ratio bit picks high/low ratio; low ratio lowers thresholds.
// RULE18: Instantaneous default: sync low once sense valid until switch-off.
// RULE19: Track-and-hold: sample at switch-off and drive sync high.
package olsc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CHANNEL_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_GENERAL_CONFIG   = 8'h04;
  localparam logic [7:0] OFS_OVERCURRENT_CFG  = 8'h08;
  localparam logic [7:0] OFS_FAULT_REPORT     = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h14;
  localparam logic [7:0] OFS_SENSE_STATUS     = 8'h18;
  // Channel config fields, per channel byte 8*ch
  localparam int BIT_PWM_EN      = 0;
  localparam int BIT_FAST_SLEW   = 1;
  localparam int BIT_PWM_ON      = 2;
  localparam int BIT_DIR_DISABLE = 5;
  localparam int BIT_ON_STATE_OPEN_LOAD_FLAG_DIS    = 6;
  // General config fields
  localparam int BIT_SENSE_A     = 0;
  localparam int BIT_SENSE_B     = 1;
  localparam int BIT_TH_EN       = 2;
  // Overcurrent config field
  localparam int BIT_LOW_RATIO   = 0;
  // Reset values
  localparam logic [15:0] RST_CHANNEL_CONFIG = 16'h0000;
  localparam logic [2:0]  RST_GENERAL_CONFIG = 3'h0;
  localparam logic        RST_LOW_RATIO      = 1'b0;
  localparam logic [3:0]  RST_IRQ_MASK       = 4'h0;
  // Timing
  localparam int CLK_MHZ               = 250;
  localparam int CHECK_PERIOD_MS       = 150;
  localparam int SENSE_SETTLE_NS       = 40;
  localparam int SETTLE_CYCLES         = (SENSE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam longint CHECK_PERIOD_CYC  = longint'(CHECK_PERIOD_MS) * 1000 * CLK_MHZ;
  // Sense output selection
  typedef enum logic [1:0] {
    SNS_NONE = 2'h0,
    SNS_CH0  = 2'h1,
    SNS_CH1  = 2'h2,
    SNS_TEMP = 2'h3
  } olsc_sense_sel_type;
  // Sync state machine, one-hot
  typedef enum logic [2:0] {
    SY_OFF    = 3'b001,
    SY_SETTLE = 3'b010,
    SY_VALID  = 3'b100
  } olsc_sync_state_type;
  // Per-channel analog comparator sample
  typedef struct packed {
    logic low_current;
    logic on;
  } olsc_chan_obs_type;
endpackage : olsc_pkg

// file: design/olsc_top.sv
// Top: open-load-in-on detection, fault flag/pin, sense routing and sync control
`timescale 1ns/10ps
`default_nettype none
module olsc_top
  import olsc_pkg::*;
#(
  parameter longint CHECK_CYCLES = CHECK_PERIOD_CYC
) (
  // Clock, reset, enable
  input  wire  logic        CLK_I,
  input  wire  logic        RESET_I,
  input  wire  logic        CE_I,
  // AHB-Lite slave
  input  wire  logic        HSEL_I,
  input  wire  logic [31:0] HADDR_I,
  input  wire  logic [1:0]  HTRANS_I,
  input  wire  logic        HWRITE_I,
  input  wire  logic [2:0]  HSIZE_I,
  input  wire  logic [31:0] HWDATA_I,
  input  wire  logic        HREADY_I,
  output var   logic [31:0] HRDATA_O,
  output var   logic        HREADYOUT_O,
  output var   logic        HRESP_O,
  // Channel control and analog observations (asynchronous)
  input  wire  logic [1:0]  DIRECT_IN_I,
  input  wire  logic [1:0]  LOW_CURRENT_I,
  input  wire  logic [1:0]  OC_WINDOW_I,
  // Outputs
  output var   logic [1:0]  CHANNEL_ON_O,
  output var   logic        FAULT_STATUS_PIN_N_O,
  output var   logic        SENSE_SYNC_PIN_N_O,
  output var   logic [1:0]  SENSE_SEL_O,
  output var   logic        SENSE_HOLD_O,
  output var   logic        SENSE_ENABLE_O,
  output var   logic        LOW_SENSE_RATIO_O,
  output var   logic        IRQ_O
);

  // Registers
  logic [15:0] channel_config_reg;
  logic [2:0]  general_config_reg;
  logic        low_ratio_reg;
  logic [1:0]  on_state_open_load_flag_reg;
  logic [3:0]  irq_status_reg;
  logic [3:0]  irq_mask_reg;

  // Two-flop synchronisers for pin inputs
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else if (CE_I) begin
      sync1_reg <= {OC_WINDOW_I, LOW_CURRENT_I, DIRECT_IN_I};
      sync2_reg <= sync1_reg;
    end
  end
  logic [1:0] dir_in;
  logic [1:0] low_cur;
  logic       oc_active;
  assign dir_in    = sync2_reg[1:0];
  assign low_cur   = sync2_reg[3:2];
  assign oc_active = |sync2_reg[5:4];

  // Channel field extraction shared by both channels
  function automatic logic cfg_bit(input logic [15:0] cfg, input int ch, input int bitpos);
    cfg_bit = cfg[ch * 8 + bitpos];
  endfunction : cfg_bit

  // AHB-Lite address phase capture
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  logic       take;
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else if (CE_I) begin
      wr_pend_reg <= take && HWRITE_I;
      rd_pend_reg <= take && !HWRITE_I;
      if (take) begin
        addr_reg <= HADDR_I[7:0];
      end
    end
  end
  // Zero wait states; every access answers OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // Channel on state: PWM bit when PWM enabled or direct input disabled, else direct input
  logic [1:0] chan_on;
  logic [1:0] chan_on_prev_reg;
  logic [1:0] turn_off;
  logic [1:0] use_pwm;
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      use_pwm[ch] = cfg_bit(channel_config_reg, ch, BIT_PWM_EN) ||
                    cfg_bit(channel_config_reg, ch, BIT_DIR_DISABLE);
      chan_on[ch] = use_pwm[ch] ? cfg_bit(channel_config_reg, ch, BIT_PWM_ON) // see RULE9
                                : dir_in[ch];
    end
  end
  assign turn_off = chan_on_prev_reg & ~chan_on;
  assign CHANNEL_ON_O = chan_on_prev_reg;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      chan_on_prev_reg <= 2'h0;
    end else if (CE_I) begin
      chan_on_prev_reg <= chan_on;
    end
  end

  // Low-ratio periodic check timer per channel (internal PWM case)
  logic [63:0] period_cnt_reg [2];
  logic [1:0]  period_due;
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      period_due[ch] = period_cnt_reg[ch] >= 64'(CHECK_CYCLES);
    end
  end

  // Check events and detected faults
  logic [1:0] check_evt;
  logic [1:0] fault_now;
  logic [1:0] clean_check_reg;
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      check_evt[ch] = 1'b0;
      fault_now[ch] = 1'b0;
      if (!cfg_bit(channel_config_reg, ch, BIT_ON_STATE_OPEN_LOAD_FLAG_DIS)) begin
        if (!low_ratio_reg) begin
          fault_now[ch] = chan_on_prev_reg[ch] && low_cur[ch];             // see RULE1
        end else if (cfg_bit(channel_config_reg, ch, BIT_FAST_SLEW)) begin // see RULE6
          // Sampled at turn-off, ahead of any off-state check
          check_evt[ch] = turn_off[ch] && (!use_pwm[ch] || period_due[ch]); // see RULE7 see RULE8
          fault_now[ch] = check_evt[ch] && low_cur[ch];
        end
      end
    end
  end

  // PWM at 100% duty never turns off, so a due check runs on the live level
  logic [1:0] full_duty_evt;
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      full_duty_evt[ch] = low_ratio_reg && use_pwm[ch] && chan_on[ch] && chan_on_prev_reg[ch] &&
                          period_due[ch] && cfg_bit(channel_config_reg, ch, BIT_FAST_SLEW) &&
                          !cfg_bit(channel_config_reg, ch, BIT_ON_STATE_OPEN_LOAD_FLAG_DIS);
    end
  end
  logic [1:0] any_evt;
  logic [1:0] any_fault;
  assign any_evt   = check_evt | full_duty_evt;
  assign any_fault = fault_now | (full_duty_evt & low_cur);

  // Period counters restart at every low-ratio check
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      period_cnt_reg[0] <= 64'h0;
      period_cnt_reg[1] <= 64'h0;
    end else if (CE_I) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (any_evt[ch]) begin
          period_cnt_reg[ch] <= 64'h0;
        end else if (!period_due[ch]) begin
          period_cnt_reg[ch] <= period_cnt_reg[ch] + 64'h1; // see RULE7
        end
      end
    end
  end

  // Fault register read strobe, data phase
  logic fault_read;
  assign fault_read = rd_pend_reg && (addr_reg == OFS_FAULT_REPORT);

  // Clean-check memory for low ratio clearing
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      clean_check_reg <= 2'h0;
    end else if (CE_I) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (any_evt[ch]) begin
          clean_check_reg[ch] <= !any_fault[ch];
        end else if (fault_read) begin
          clean_check_reg[ch] <= 1'b0;
        end
      end
    end
  end

  // Latched on-state open-load flag; a new fault wins over a clear
  logic [1:0] flag_clear;
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      if (!low_ratio_reg) begin
        flag_clear[ch] = fault_read && (!chan_on_prev_reg[ch] || !low_cur[ch]); // see RULE4 see RULE5
      end else begin
        flag_clear[ch] = fault_read && clean_check_reg[ch];                     // see RULE10
      end
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      on_state_open_load_flag_reg <= 2'h0;
    end else if (CE_I) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (any_fault[ch]) begin
          on_state_open_load_flag_reg[ch] <= 1'b1; // see RULE2
        end else if (flag_clear[ch]) begin
          on_state_open_load_flag_reg[ch] <= 1'b0; // see RULE3
        end
      end
    end
  end

  // Live fault pin: follows the cause, not the latch; channel is left on
  logic [1:0] cause_reg;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cause_reg <= 2'h0;
    end else if (CE_I) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!low_ratio_reg) begin
          cause_reg[ch] <= fault_now[ch];                        // see RULE2 see RULE3
        end else if (any_evt[ch]) begin
          cause_reg[ch] <= any_fault[ch];
        end else if (cfg_bit(channel_config_reg, ch, BIT_ON_STATE_OPEN_LOAD_FLAG_DIS)) begin
          cause_reg[ch] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      FAULT_STATUS_PIN_N_O <= 1'b1;
    end else if (CE_I) begin
      FAULT_STATUS_PIN_N_O <= ~|cause_reg; // see RULE2 see RULE3
    end
  end

  // Sense routing selection
  olsc_sense_sel_type sense_sel;
  always_comb begin
    case ({general_config_reg[BIT_SENSE_B], general_config_reg[BIT_SENSE_A]})
      2'b01:   sense_sel = SNS_CH0;  // see RULE11 see RULE12
      2'b10:   sense_sel = SNS_CH1;  // see RULE12
      2'b11:   sense_sel = SNS_TEMP; // see RULE12
      default: sense_sel = SNS_NONE;
    endcase
  end
  logic sel_on;
  logic sel_off_evt;
  logic sel_is_chan;
  assign sel_is_chan = (sense_sel == SNS_CH0) || (sense_sel == SNS_CH1);
  assign sel_on      = (sense_sel == SNS_CH1) ? chan_on_prev_reg[1] : chan_on_prev_reg[0];
  assign sel_off_evt = (sense_sel == SNS_CH1) ? turn_off[1] : turn_off[0];

  // Sync state machine: settle after turn-on, valid until switch-off
  olsc_sync_state_type sync_state_reg;
  olsc_sync_state_type sync_state_next;
  logic [7:0]          settle_cnt_reg;
  always_comb begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      SY_OFF: begin
        if (sel_is_chan && sel_on && !oc_active) begin
          sync_state_next = SY_SETTLE;
        end
      end
      SY_SETTLE: begin
        if (!sel_on || oc_active || !sel_is_chan) begin
          sync_state_next = SY_OFF;
        end else if (settle_cnt_reg == 8'(SETTLE_CYCLES - 1)) begin
          sync_state_next = SY_VALID;
        end
      end
      SY_VALID: begin
        if (!sel_on || oc_active || !sel_is_chan) begin
          sync_state_next = SY_OFF; // see RULE18
        end
      end
      default: sync_state_next = SY_OFF;
    endcase
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync_state_reg <= SY_OFF;
      settle_cnt_reg <= 8'h00;
    end else if (CE_I) begin
      sync_state_reg <= sync_state_next;
      settle_cnt_reg <= (sync_state_reg == SY_SETTLE) ? settle_cnt_reg + 8'h01 : 8'h00;
    end
  end

  // Hold latch for track-and-hold; set at switch-off, lost on reselect
  logic hold_reg;
  logic th_mode;
  logic [1:0] prev_sel_reg;
  assign th_mode = general_config_reg[BIT_TH_EN]; // see RULE14
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hold_reg     <= 1'b0;
      prev_sel_reg <= 2'h0;
    end else if (CE_I) begin
      prev_sel_reg <= sense_sel;
      // The switch-off cycle still shows the channel on, so it must not clear the hold
      if (!th_mode || sense_sel != olsc_sense_sel_type'(prev_sel_reg) || (sel_on && !sel_off_evt)) begin
        hold_reg <= 1'b0;
      end else if (sel_off_evt && sync_state_reg == SY_VALID) begin
        hold_reg <= 1'b1; // see RULE16 see RULE19
      end
    end
  end

  // Sense and sync outputs
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SENSE_SEL_O        <= SNS_NONE;
      SENSE_HOLD_O       <= 1'b0;
      SENSE_ENABLE_O     <= 1'b0;
      SENSE_SYNC_PIN_N_O <= 1'b1;
      LOW_SENSE_RATIO_O  <= RST_LOW_RATIO;
    end else if (CE_I) begin
      SENSE_SEL_O        <= sense_sel;
      SENSE_HOLD_O       <= hold_reg;
      // Channel current only while on, or held; temperature at any time; nothing in an overcurrent window
      SENSE_ENABLE_O     <= !oc_active && (sense_sel == SNS_TEMP ||                  // see RULE13
                            (sel_is_chan && (sel_on || (th_mode && hold_reg))));     // see RULE15
      SENSE_SYNC_PIN_N_O <= !(sync_state_next == SY_VALID) || oc_active;             // see RULE13 see RULE18
      LOW_SENSE_RATIO_O  <= low_ratio_reg; // see RULE17
    end
  end

  // Register writes
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      channel_config_reg <= RST_CHANNEL_CONFIG;
      general_config_reg <= RST_GENERAL_CONFIG;
      low_ratio_reg      <= RST_LOW_RATIO;
      irq_mask_reg       <= RST_IRQ_MASK;
    end else if (CE_I && wr_pend_reg) begin
      case (addr_reg)
        OFS_CHANNEL_CONFIG:  channel_config_reg <= HWDATA_I[15:0];
        OFS_GENERAL_CONFIG:  general_config_reg <= HWDATA_I[2:0];
        OFS_OVERCURRENT_CFG: low_ratio_reg      <= HWDATA_I[BIT_LOW_RATIO]; // see RULE17
        OFS_IRQ_MASK:        irq_mask_reg       <= HWDATA_I[3:0];
        default: ;
      endcase
    end
  end

  // Interrupt status: set on each detected fault or check event; read clears, set wins
  logic       irq_read;
  logic [3:0] irq_set;
  assign irq_read = rd_pend_reg && (addr_reg == OFS_IRQ_STATUS);
  assign irq_set  = {any_evt, any_fault};
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_status_reg <= 4'h0;
    end else if (CE_I) begin
      irq_status_reg <= (irq_read ? 4'h0 : irq_status_reg) | irq_set;
    end
  end
  assign IRQ_O = |(irq_status_reg & irq_mask_reg);

  // Read data mux; unmapped offsets read zero
  always_comb begin
    case (addr_reg)
      OFS_CHANNEL_CONFIG:  HRDATA_O = {16'h0000, channel_config_reg};
      OFS_GENERAL_CONFIG:  HRDATA_O = {29'h0, general_config_reg};
      OFS_OVERCURRENT_CFG: HRDATA_O = {31'h0, low_ratio_reg};
      OFS_FAULT_REPORT:    HRDATA_O = {28'h0, cause_reg, on_state_open_load_flag_reg};
      OFS_IRQ_STATUS:      HRDATA_O = {28'h0, irq_status_reg};
      OFS_IRQ_MASK:        HRDATA_O = {28'h0, irq_mask_reg};
      OFS_SENSE_STATUS:    HRDATA_O = {26'h0, hold_reg, sync_state_reg, sense_sel};
      default:             HRDATA_O = 32'h0;
    endcase
  end

endmodule : olsc_top
`default_nettype wire

// file: tb/olsc_load_model.sv
// Load model: low-current comparator seen by the block
`timescale 1ns/10ps
`default_nettype none
module olsc_load_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Load condition and comparator output
  input  wire logic [1:0] open_i,
  output var  logic [1:0] low_current_o
);
  // Comparator lags the load by one cycle, as a real filter would
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_current_o <= 2'b00;
    end else begin
      low_current_o <= open_i;
    end
  end
endmodule : olsc_load_model
`default_nettype wire

// file: tb/olsc_props.sv
// Checker: port-level properties of the open-load and sense block
`timescale 1ns/10ps
`default_nettype none
module olsc_props
  import olsc_pkg::*;
(
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  // Bus
  input wire logic       HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic       HWRITE_I,
  input wire logic       HREADY_I,
  input wire logic       HREADYOUT_O,
  input wire logic       HRESP_O,
  // Pins
  input wire logic [1:0] LOW_CURRENT_I,
  input wire logic [1:0] OC_WINDOW_I,
  input wire logic [1:0] CHANNEL_ON_O,
  input wire logic       FAULT_STATUS_PIN_N_O,
  input wire logic       SENSE_SYNC_PIN_N_O,
  input wire logic [1:0] SENSE_SEL_O,
  input wire logic       SENSE_HOLD_O,
  input wire logic       SENSE_ENABLE_O,
  input wire logic       LOW_SENSE_RATIO_O,
  input wire logic       IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic       taken;
  logic [3:0] lc_age_reg;
  logic [7:0] on_cnt_reg;
  // Bus request accepted this edge
  assign taken = HSEL_I && HTRANS_I[1] && HREADY_I;
  // Cycles since a low-current report, saturating
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lc_age_reg <= 4'hf;
    end else if (|LOW_CURRENT_I) begin
      lc_age_reg <= 4'h0;
    end else if (lc_age_reg != 4'hf) begin
      lc_age_reg <= lc_age_reg + 4'h1;
    end
  end
  // Conduction time, so sync cannot drop before settling
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      on_cnt_reg <= 8'h0;
    end else if (CHANNEL_ON_O == 2'b00) begin
      on_cnt_reg <= 8'h0;
    end else if (on_cnt_reg != 8'hff) begin
      on_cnt_reg <= on_cnt_reg + 8'h1;
    end
  end
  sequence s_oc_held;
    (&OC_WINDOW_I)[*5];
  endsequence
  sequence s_hold_rise;
    $rose(SENSE_HOLD_O);
  endsequence
  chk_fault_cause: assert property (!LOW_SENSE_RATIO_O && $fell(FAULT_STATUS_PIN_N_O) |-> lc_age_reg <= 4'h6)
    else $error("fault pin fell without low current");
  chk_pin_on_only: assert property (!LOW_SENSE_RATIO_O && !FAULT_STATUS_PIN_N_O |->
    (|CHANNEL_ON_O) || (|$past(CHANNEL_ON_O, 1)) || (|$past(CHANNEL_ON_O, 2)) || (|$past(CHANNEL_ON_O, 3)))
    else $error("fault pin low while channel off");
  chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or error response");
  chk_irq_clear: assert property ($fell(IRQ_O) |-> $past(taken, 2))
    else $error("interrupt dropped without a bus access");
  chk_ratio_write: assert property ($changed(LOW_SENSE_RATIO_O) |->
    $past(taken && HWRITE_I, 2) || $past(taken && HWRITE_I, 3))
    else $error("ratio changed without a write");
  chk_sel_write: assert property ($changed(SENSE_SEL_O) |->
    $past(taken && HWRITE_I, 2) || $past(taken && HWRITE_I, 3))
    else $error("sense selection changed without a write");
  chk_oc_quiet: assert property (s_oc_held |-> SENSE_SYNC_PIN_N_O && !SENSE_ENABLE_O)
    else $error("sensing active inside overcurrent window");
  chk_sync_settle: assert property ($fell(SENSE_SYNC_PIN_N_O) |-> on_cnt_reg >= 8'(SETTLE_CYCLES - 2))
    else $error("sync fell before settling");
  chk_sync_off: assert property (!SENSE_SYNC_PIN_N_O |->
    (|CHANNEL_ON_O) || (|$past(CHANNEL_ON_O, 1)) || (|$past(CHANNEL_ON_O, 2)))
    else $error("sync low while channel off");
  chk_hold_sync: assert property (s_hold_rise |-> ##[0:2] SENSE_SYNC_PIN_N_O)
    else $error("sync not high after hold sample");
endmodule : olsc_props
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: register, open-load and sense scenarios against a small model
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import olsc_pkg::*;
;
  // Design pins
  logic        clk, rst, hsel, hwrite, hready, hresp, fault_n, sync_n, hold, sns_en, low_ratio, irq;
  logic [1:0]  htrans, dir_in, oc_win, open, low_cur, ch_on, sel;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  // Model state and counters
  int          miscompares, total_checks, cycles, seed, ratio;
  int          exp_flag[2], clean[2];
  logic [7:0]  ofs_tab[5] = '{OFS_CHANNEL_CONFIG, OFS_GENERAL_CONFIG, OFS_OVERCURRENT_CFG, OFS_IRQ_MASK, 8'h40};
  logic [31:0] rst_tab[5] = '{32'(RST_CHANNEL_CONFIG), 32'(RST_GENERAL_CONFIG), 32'(RST_LOW_RATIO),
                              32'(RST_IRQ_MASK), 32'h0};
  // 250 MHz clock
  always #2 clk = ~clk;
  // Design with a short check period
  olsc_top #(.CHECK_CYCLES(20)) uut (
    .CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .DIRECT_IN_I(dir_in), .LOW_CURRENT_I(low_cur),
    .OC_WINDOW_I(oc_win), .CHANNEL_ON_O(ch_on), .FAULT_STATUS_PIN_N_O(fault_n),
    .SENSE_SYNC_PIN_N_O(sync_n), .SENSE_SEL_O(sel), .SENSE_HOLD_O(hold), .SENSE_ENABLE_O(sns_en),
    .LOW_SENSE_RATIO_O(low_ratio), .IRQ_O(irq));
  // Load side
  olsc_load_model load (.clk_i(clk), .rst_i(rst), .open_i(open), .low_current_o(low_cur));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One single AHB-Lite transfer; two extra edges let registered outputs settle
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    repeat (2) @(posedge clk);
  endtask : bus
  // Read the fault report, compare flags, then apply the clear rules
  task automatic rd_fault();
    bus(1'b0, OFS_FAULT_REPORT, 32'h0);
    check({30'h0, rd[1:0]}, {30'h0, exp_flag[1][0], exp_flag[0][0]});
    for (int c = 0; c < 2; c++) begin
      if (ratio == 0 && (dir_in[c] == 1'b0 || open[c] == 1'b0)) exp_flag[c] = 0;
      if (ratio == 1 && clean[c] == 1) exp_flag[c] = 0;
      if (ratio == 1) clean[c] = 0;
    end
  endtask : rd_fault
  // Low-ratio direct pulse on channel 1; a check runs at turn-off when fast slew is set (fast == 1)
  task automatic pulse(input int fast);
    dir_in[1] <= 1'b1;
    repeat (16 + ($random(seed) & 15)) @(posedge clk);
    dir_in[1] <= 1'b0;
    repeat (20) @(posedge clk);
    if (fast == 1 && open[1] == 1'b1) exp_flag[1] = 1;
    if (fast == 1) clean[1] = (open[1] == 1'b0);
  endtask : pulse
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Hang guard, well above the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, dir_in, oc_win, open} = '0;
    hsize = 3'h2;
    seed = 64042;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs_tab[i]) begin
      bus(1'b0, ofs_tab[i], 32'h0);
      check(rd, rst_tab[i]);
    end
    // High ratio open load on channel 0, interrupt raised, masked, cleared
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    dir_in[0] <= 1'b1;
    repeat (8) @(posedge clk);
    open[0] <= 1'b1;
    repeat (10) @(posedge clk);
    exp_flag[0] = 1;
    check(32'(fault_n), 32'h0);
    check(32'(ch_on), 32'h1);
    check(32'(irq), 32'h1);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    check(32'(irq), 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    check(32'(irq), 32'h1);
    rd_fault();
    rd_fault();
    open[0] <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(fault_n), 32'h1);
    rd_fault();
    rd_fault();
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(32'(rd[0]), 32'h1);
    check(32'(irq), 32'h0);
    open[0] <= 1'b1;
    repeat (10) @(posedge clk);
    exp_flag[0] = 1;
    dir_in[0] <= 1'b0;
    repeat (8) @(posedge clk);
    rd_fault();
    rd_fault();
    open[0] <= 1'b0;
    // Every sense selection code
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_GENERAL_CONFIG, ($random(seed) & 32'hffff_ff00) | s);
      check(32'(sel), 32'(s));
    end
    bus(1'b1, OFS_GENERAL_CONFIG, 32'h1);
    dir_in[0] <= 1'b1;
    repeat (24) @(posedge clk);
    check(32'({sync_n, sns_en}), 32'h1);
    dir_in[0] <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'({sync_n, sns_en}), 32'h2);
    bus(1'b1, OFS_GENERAL_CONFIG, 32'h5);
    dir_in[0] <= 1'b1;
    repeat (24) @(posedge clk);
    dir_in[0] <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'({sync_n, hold}), 32'h3);
    bus(1'b1, OFS_GENERAL_CONFIG, 32'h1);
    dir_in[0] <= 1'b1;
    oc_win <= 2'b11;
    repeat (12) @(posedge clk);
    check(32'({sync_n, sns_en}), 32'h2);
    oc_win <= 2'b00;
    dir_in[0] <= 1'b0;
    // Low ratio checks on channel 1
    bus(1'b1, OFS_OVERCURRENT_CFG, 32'h1);
    ratio = 1;
    check(32'(low_ratio), 32'h1);
    open[1] <= 1'b1;
    pulse(0);
    rd_fault();
    bus(1'b1, OFS_CHANNEL_CONFIG, 32'h200);
    pulse(1);
    rd_fault();
    open[1] <= 1'b0;
    rd_fault();
    pulse(1);
    rd_fault();
    rd_fault();
    // Direct input ignored, internal path at full duty
    bus(1'b1, OFS_CHANNEL_CONFIG, 32'h2600);
    open[1] <= 1'b1;
    repeat (6) @(posedge clk);
    repeat (60) begin
      dir_in[1] <= 1'($random(seed));
      @(posedge clk);
      check(32'(ch_on[1]), 32'h1);
    end
    exp_flag[1] = 1;
    rd_fault();
    wrap_up();
  end
endmodule : tb_top
bind olsc_top olsc_props chk (
  .CLK_I, .RESET_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HREADYOUT_O, .HRESP_O, .LOW_CURRENT_I,
  .OC_WINDOW_I, .CHANNEL_ON_O, .FAULT_STATUS_PIN_N_O, .SENSE_SYNC_PIN_N_O, .SENSE_SEL_O, .SENSE_HOLD_O,
  .SENSE_ENABLE_O, .LOW_SENSE_RATIO_O, .IRQ_O);
`default_nettype wire
